// ===== src/anode_cfg.svh
`ifndef ANODE_CFG_SVH
`define ANODE_CFG_SVH

// register indices
`define REG_DEVICE_ID 8'h00
`define REG_NODE_CONFIG 8'h04
`define REG_NODE_ID 8'h05
`define REG_RESET_MODE 8'h50
`define REG_SYSCLK_FREQ 8'h51
`define REG_LINK_CTRL 8'h80
`define REG_WDOG_CTRL 8'hD6
`define REG_WDOG_DISABLE 8'hD7

// identification fields
`define ID_CHIP_MSB 31
`define ID_CHIP_LSB 24
`define ID_OSC_BIT 16
`define ID_REV_MSB 15
`define ID_REV_LSB 8
`define ID_VER_MSB 7
`define ID_VER_LSB 0

// node configuration fields
`define NCFG_LOCK_BIT 31
`define NCFG_HDR_BIT 0
`define NODE_ID_MSB 15

// reset and mode control fields
`define RMC_TRI_BIT 24
`define RMC_MODE_MSB 17
`define RMC_MODE_LSB 16
`define RMC_USB_ACC_BIT 3
`define RMC_USB_EN_BIT 2
`define RMC_TILE_RST_BIT 1
`define RMC_SYS_RST_BIT 0

// system clock frequency field
`define FREQ_MSB 6
`define FREQ_MIN 7'h05
`define FREQ_MAX 7'h64
`define FREQ_RESET 7'h19

// link control layout
`define LINK_RW_MASK 32'h003F_FFFF
`define LINK_RESET 32'h0000_0801

// watchdog
`define WDOG_CTRL_RESET 16'h03E8
`define WDOG_DISABLE_RESET 32'h0D15_AB1E

// reset timing
`define SYS_RESET_CYCLES 524288
`define TILE_RESET_CYCLES 16

`endif

// ===== src/anode_pkg.sv
package anode_pkg;

   typedef struct packed {
      logic valid;
      logic write;
      logic resp_req;
      logic [7:0] index;
      logic [31:0] wdata;
   } cfg_req_type;

   typedef struct packed {
      logic valid;
      logic ack;
      logic [31:0] rdata;
   } cfg_resp_type;

   typedef struct packed {
      logic tristate;
      logic [1:0] mode;
      logic usb_access;
      logic usb_enable;
   } mode_ctrl_type;

   typedef enum logic [1:0] {
      RST_IDLE,
      RST_SYSTEM,
      RST_TILE
   } reset_state_type;

endpackage : anode_pkg

// ===== src/reset_timer.sv
`timescale 1ns/1ns
`default_nettype none

// counts a fixed number of cycles, restarting on every new trigger
module reset_timer
   import anode_pkg::*;
#(
   parameter int COUNT = 524288
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic trigger,
   output logic busy
);

   localparam int CW = $clog2(COUNT + 1);

   initial begin
      if (COUNT < 1) begin
         $error("reset_timer: COUNT must be at least one");
      end
   end

   logic [CW-1:0] remaining;
   logic [CW-1:0] next_remaining;

   assign next_remaining = trigger ? CW'(COUNT) :
      (remaining != '0) ? remaining - CW'(1) : remaining;
   assign busy = (remaining != '0);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         remaining <= '0;
      end else begin
         remaining <= next_remaining;
      end
   end

endmodule : reset_timer

`default_nettype wire

// ===== src/analog_node_reset_config.sv
// Function
// RULE1 - id register: chip, revision, version fields
// RULE2 - id bit 16 shows oscillator select strap
// RULE3 - lock bit freezes node config, link control
// RULE4 - node config bit 0 selects header format
// RULE5 - 16-bit writable node id, upper reserved
// RULE6 - separate system and tile reset scopes
// RULE7 - pin, brownout, watchdog, software raise system reset
// RULE8 - sleep, clock change, software raise tile reset
// RULE9 - system reset lasts 524,288 oscillator cycles
// RULE10 - fixed cycle count, duration scales with clock
// RULE11 - mode pins driven, bit 24 tristates them
// RULE12 - bit 3 gates usb register access
// RULE13 - bit 2 enables usb, zero resets it
// RULE14 - write-only bit 1 starts tile reset
// RULE15 - write-only bit 0 starts system reset
// RULE16 - reset-bit writes send no response packet
// RULE17 - clock frequency accepts 5..100, else nack
// RULE18 - reserved bits read zero, ignore writes
// RULE19 - new system source restarts reset count
`timescale 1ns/1ns
`default_nettype none
`include "anode_cfg.svh"

module analog_node_reset_config
   import anode_pkg::*;
#(
   parameter int SYS_RESET_CYCLES = `SYS_RESET_CYCLES,
   parameter int TILE_RESET_CYCLES = `TILE_RESET_CYCLES,
   // arbitrary identification values
   parameter logic [7:0] CHIP_ID = 8'hA5,
   parameter logic [7:0] ANALOG_REVISION = 8'h11,
   parameter logic [7:0] ANALOG_VERSION = 8'h22
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration packets
   input wire cfg_req_type cfg_req,
   output cfg_resp_type cfg_resp,
   // strap
   input wire logic oscillator_select_pin,
   // reset sources
   input wire logic ext_reset_pin_n,
   input wire logic brownout,
   input wire logic watchdog_expired,
   input wire logic sleep_sequence_reset,
   input wire logic clock_source_change,
   // reset outputs
   output logic system_reset,
   output logic tile_reset,
   // processor mode pins
   output logic [1:0] mode_pins_out,
   output logic [1:0] mode_pins_oe,
   // usb control
   output logic usb_access_enable,
   output logic usb_enable,
   output logic usb_reset,
   // node settings
   output logic one_byte_headers,
   output logic [15:0] node_id_value,
   output logic [6:0] sysclk_mhz,
   output logic [31:0] link_control,
   output logic [15:0] watchdog_timeout,
   output logic [31:0] watchdog_disable_value
);

   initial begin
      if (SYS_RESET_CYCLES < 1 || TILE_RESET_CYCLES < 1) begin
         $error("analog_node_reset_config: reset counts must be positive");
      end
   end

   // ==========================================================
   // decode
   // ==========================================================
   function automatic logic hit(input cfg_req_type r, input logic [7:0] idx);
      hit = r.valid && (r.index == idx);
   endfunction : hit

   function automatic logic wr_hit(input cfg_req_type r,
                                   input logic [7:0] idx);
      wr_hit = hit(r, idx) && r.write;
   endfunction : wr_hit

   logic locked;
   logic hdr_mode;
   logic [15:0] node_id;
   mode_ctrl_type mode_ctrl;
   logic [6:0] freq;
   logic [31:0] link_reg;
   logic [15:0] wdog_timeout;
   logic [31:0] wdog_disable;
   logic osc_strap;
   logic strap_taken;

   wire wr_ncfg = wr_hit(cfg_req, `REG_NODE_CONFIG) && !locked; // RULE3
   wire wr_nid = wr_hit(cfg_req, `REG_NODE_ID);
   wire wr_rmc = wr_hit(cfg_req, `REG_RESET_MODE);
   wire wr_freq_hit = wr_hit(cfg_req, `REG_SYSCLK_FREQ);
   wire wr_link = wr_hit(cfg_req, `REG_LINK_CTRL) && !locked; // RULE3
   wire wr_wctl = wr_hit(cfg_req, `REG_WDOG_CTRL);
   wire wr_wdis = wr_hit(cfg_req, `REG_WDOG_DISABLE);

   wire [6:0] wr_freq_val = cfg_req.wdata[`FREQ_MSB:0];
   wire freq_ok = (cfg_req.wdata[31:7] == '0) &&
      (wr_freq_val >= `FREQ_MIN) && (wr_freq_val <= `FREQ_MAX); // RULE17
   wire wr_freq = wr_freq_hit && freq_ok; // RULE17

   wire sw_sys_rst = wr_rmc && cfg_req.wdata[`RMC_SYS_RST_BIT]; // RULE15
   wire sw_tile_rst = wr_rmc && cfg_req.wdata[`RMC_TILE_RST_BIT]; // RULE14
   wire mapped = hit(cfg_req, `REG_DEVICE_ID) ||
      hit(cfg_req, `REG_NODE_CONFIG) || hit(cfg_req, `REG_NODE_ID) ||
      hit(cfg_req, `REG_RESET_MODE) || hit(cfg_req, `REG_SYSCLK_FREQ) ||
      hit(cfg_req, `REG_LINK_CTRL) || hit(cfg_req, `REG_WDOG_CTRL) ||
      hit(cfg_req, `REG_WDOG_DISABLE);

   // ==========================================================
   // read mux
   // ==========================================================
   logic [31:0] id_word;
   always_comb begin
      id_word = '0;
      id_word[`ID_CHIP_MSB:`ID_CHIP_LSB] = CHIP_ID; // RULE1
      id_word[`ID_OSC_BIT] = osc_strap; // RULE2
      id_word[`ID_REV_MSB:`ID_REV_LSB] = ANALOG_REVISION; // RULE1
      id_word[`ID_VER_MSB:`ID_VER_LSB] = ANALOG_VERSION; // RULE1
   end

   logic [31:0] rmc_word;
   always_comb begin
      rmc_word = '0; // RULE18
      rmc_word[`RMC_TRI_BIT] = mode_ctrl.tristate;
      rmc_word[`RMC_MODE_MSB:`RMC_MODE_LSB] = mode_ctrl.mode;
      rmc_word[`RMC_USB_ACC_BIT] = mode_ctrl.usb_access;
      rmc_word[`RMC_USB_EN_BIT] = mode_ctrl.usb_enable;
   end

   logic [31:0] read_word;
   always_comb begin
      case (cfg_req.index)
         `REG_DEVICE_ID: read_word = id_word;
         `REG_NODE_CONFIG: read_word = {locked, 30'h0, hdr_mode}; // RULE18
         `REG_NODE_ID: read_word = {16'h0, node_id}; // RULE5
         `REG_RESET_MODE: read_word = rmc_word;
         `REG_SYSCLK_FREQ: read_word = {25'h0, freq};
         `REG_LINK_CTRL: read_word = link_reg;
         `REG_WDOG_CTRL: read_word = {16'h0, wdog_timeout};
         `REG_WDOG_DISABLE: read_word = wdog_disable;
         default: read_word = '0;
      endcase
   end

   // ==========================================================
   // strap capture after reset release
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         strap_taken <= 1'b0;
         osc_strap <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         osc_strap <= oscillator_select_pin; // RULE2
      end
   end

   // ==========================================================
   // reset generation
   // ==========================================================
   logic sys_busy;
   logic sys_rst_q;
   logic [$clog2(TILE_RESET_CYCLES + 1)-1:0] tile_count;
   reset_state_type state;
   reset_state_type next_state;

   // every new system source restarts the timer
   wire sys_trigger = !ext_reset_pin_n || brownout || watchdog_expired ||
      sw_sys_rst; // RULE7 RULE19
   wire tile_trigger = sleep_sequence_reset || clock_source_change ||
      sw_tile_rst; // RULE8

   reset_timer #(
      .COUNT(SYS_RESET_CYCLES)
   ) u_sys_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .trigger(sys_trigger),
      .busy(sys_busy)
   ); // RULE9 RULE10

   always_comb begin
      case (state)
         RST_IDLE: next_state = sys_trigger ? RST_SYSTEM :
            tile_trigger ? RST_TILE : RST_IDLE;
         RST_SYSTEM: next_state = (sys_busy || sys_trigger) ? RST_SYSTEM :
            RST_IDLE;
         RST_TILE: next_state = sys_trigger ? RST_SYSTEM :
            (tile_count != '0 || tile_trigger) ? RST_TILE : RST_IDLE;
         default: next_state = RST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= RST_IDLE;
         tile_count <= '0;
      end else begin
         state <= next_state;
         if (tile_trigger) begin
            tile_count <= ($bits(tile_count))'(TILE_RESET_CYCLES);
         end else if (tile_count != '0) begin
            tile_count <= tile_count - 1'b1;
         end
      end
   end

   assign sys_rst_q = (state == RST_SYSTEM);
   assign system_reset = sys_rst_q; // RULE6
   assign tile_reset = (state != RST_IDLE); // RULE6

   // ==========================================================
   // registers
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n || sys_rst_q) begin
         locked <= 1'b0;
         hdr_mode <= 1'b0; // RULE4
         node_id <= '0; // RULE5
         mode_ctrl <= '0; // RULE12 RULE13
         freq <= `FREQ_RESET;
         link_reg <= `LINK_RESET;
         wdog_timeout <= `WDOG_CTRL_RESET;
         wdog_disable <= `WDOG_DISABLE_RESET;
      end else begin
         if (wr_ncfg) begin
            locked <= cfg_req.wdata[`NCFG_LOCK_BIT]; // RULE3
            hdr_mode <= cfg_req.wdata[`NCFG_HDR_BIT]; // RULE4
         end
         if (wr_nid) begin
            node_id <= cfg_req.wdata[`NODE_ID_MSB:0]; // RULE5
         end
         if (wr_rmc) begin
            mode_ctrl.tristate <= cfg_req.wdata[`RMC_TRI_BIT]; // RULE11
            mode_ctrl.mode <=
               cfg_req.wdata[`RMC_MODE_MSB:`RMC_MODE_LSB]; // RULE11
            mode_ctrl.usb_access <= cfg_req.wdata[`RMC_USB_ACC_BIT]; // RULE12
            mode_ctrl.usb_enable <= cfg_req.wdata[`RMC_USB_EN_BIT]; // RULE13
         end
         if (wr_freq) begin
            freq <= wr_freq_val; // RULE17
         end
         if (wr_link) begin
            link_reg <= cfg_req.wdata & `LINK_RW_MASK; // RULE18
         end
         if (wr_wctl) begin
            wdog_timeout <= cfg_req.wdata[15:0];
         end
         if (wr_wdis) begin
            wdog_disable <= cfg_req.wdata;
         end
      end
   end

   // ==========================================================
   // response
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cfg_resp <= '0;
      end else begin
         cfg_resp.valid <= cfg_req.valid && cfg_req.resp_req &&
            !(sw_sys_rst || sw_tile_rst); // RULE16
         cfg_resp.ack <= mapped && !(wr_freq_hit && !freq_ok); // RULE17
         cfg_resp.rdata <= cfg_req.write ? 32'h0 : read_word;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign mode_pins_out = mode_ctrl.mode; // RULE11
   assign mode_pins_oe = {2{!mode_ctrl.tristate}}; // RULE11
   assign usb_access_enable = mode_ctrl.usb_access; // RULE12
   assign usb_enable = mode_ctrl.usb_enable; // RULE13
   assign usb_reset = !mode_ctrl.usb_enable; // RULE13
   assign one_byte_headers = hdr_mode;
   assign node_id_value = node_id;
   assign sysclk_mhz = freq;
   assign link_control = link_reg;
   assign watchdog_timeout = wdog_timeout;
   assign watchdog_disable_value = wdog_disable;

endmodule : analog_node_reset_config

`default_nettype wire

// ===== tb/anode_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module anode_assertions
   import anode_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration packets
   input wire cfg_req_type cfg_req,
   input wire cfg_resp_type cfg_resp,
   // reset sources
   input wire logic ext_reset_pin_n,
   input wire logic brownout,
   input wire logic watchdog_expired,
   input wire logic sleep_sequence_reset,
   input wire logic clock_source_change,
   // outputs watched
   input wire logic system_reset,
   input wire logic tile_reset,
   input wire logic [1:0] mode_pins_out,
   input wire logic [1:0] mode_pins_oe,
   input wire logic usb_enable,
   input wire logic usb_reset
);
   // ==========================================
   // helpers
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] last_wdata;
   wire take = cfg_req.valid && cfg_req.write && !system_reset;
   wire wr50 = take && cfg_req.index == 8'h50;
   wire plain50 = wr50 && cfg_req.wdata[1:0] == 2'h0;
   wire bad_freq = cfg_req.wdata > 32'h64 || cfg_req.wdata < 32'h05;
   always_ff @(posedge ref_clk) begin
      last_wdata <= cfg_req.wdata;
   end
   // ==========================================
   // properties
   a_reset_no_resp: assert property (
      wr50 && cfg_req.wdata[1:0] != 2'h0 |=> !cfg_resp.valid)
      else $error("response after reset write");
   a_mode_pins_set: assert property (
      plain50 |=> mode_pins_out == last_wdata[17:16]
         && mode_pins_oe == {2{!last_wdata[24]}})
      else $error("mode pins differ from write");
   a_usb_enable_set: assert property (
      plain50 |=> usb_enable == last_wdata[2] && usb_reset == !last_wdata[2])
      else $error("usb enable differs from write");
   a_sys_src_start: assert property (
      !ext_reset_pin_n || brownout || watchdog_expired |=> system_reset)
      else $error("system source did not reset");
   a_tile_src_start: assert property (
      sleep_sequence_reset || clock_source_change |=> tile_reset)
      else $error("tile source did not reset");
   a_sys_hold_min: assert property (
      $rose(system_reset) |-> system_reset [*8])
      else $error("system reset too short");
   a_freq_range_nack: assert property (
      take && cfg_req.resp_req && cfg_req.index == 8'h51 && bad_freq
      |=> cfg_resp.valid && !cfg_resp.ack)
      else $error("bad frequency not refused");
   a_soft_sys_start: assert property (
      wr50 && cfg_req.wdata[0] |=> system_reset && tile_reset)
      else $error("software system reset missing");
endmodule : anode_assertions
`default_nettype wire

// ===== tb/cfg_master.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_master
   import anode_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // configuration packets
   output var cfg_req_type cfg_req,
   input wire cfg_resp_type cfg_resp
);
   initial cfg_req = '0;
   // one request; released fields are inverted, not left stale
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output cfg_resp_type rsp);
      @(posedge ref_clk);
      cfg_req <= '{1'b1, wr, 1'b1, idx, wd};
      @(posedge ref_clk);
      cfg_req <= cfg_req_type'({1'b0, ~cfg_req[41:0]});
      #1 rsp = cfg_resp;
   endtask : xfer
endmodule : cfg_master
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
   import anode_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic osc_pin = 1'b1;
   logic [6:0] sysclk_mhz;
   logic [31:0] link_control, watchdog_disable_value;
   logic [15:0] watchdog_timeout;
   logic [4:0] src = 5'h01;
   cfg_req_type cfg_req;
   cfg_resp_type cfg_resp, rsp;
   logic system_reset, tile_reset, usb_access_enable, usb_enable, usb_reset;
   logic one_byte_headers;
   logic [1:0] mode_pins_out, mode_pins_oe;
   logic [15:0] node_id_value;
   int miscompares = 0;
   int samples_checked = 0;
   int n;
   logic [31:0] fv [4] = '{32'h04, 32'h05, 32'h65, 32'h64};
   always #4 ref_clk = ~ref_clk;
   analog_node_reset_config #(.SYS_RESET_CYCLES(20)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
      .cfg_resp(cfg_resp), .oscillator_select_pin(osc_pin),
      .ext_reset_pin_n(src[0]), .brownout(src[1]),
      .watchdog_expired(src[2]), .sleep_sequence_reset(src[3]),
      .clock_source_change(src[4]), .system_reset(system_reset),
      .tile_reset(tile_reset), .mode_pins_out(mode_pins_out),
      .mode_pins_oe(mode_pins_oe), .usb_access_enable(usb_access_enable),
      .usb_enable(usb_enable), .usb_reset(usb_reset),
      .one_byte_headers(one_byte_headers), .node_id_value(node_id_value),
      .sysclk_mhz(sysclk_mhz), .link_control(link_control),
      .watchdog_timeout(watchdog_timeout),
      .watchdog_disable_value(watchdog_disable_value));
   cfg_master m (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_resp(cfg_resp));
   // ==========================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      m.xfer(1'b0, idx, 32'h0, rsp);
      check(rsp.rdata, exp);
   endtask : rd
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      m.xfer(1'b1, idx, wd, rsp);
   endtask : wr
   task automatic hold_len(input bit sys, output int k);
      k = 0;
      while ((sys ? system_reset : tile_reset) === 1'b1 && k < 200) begin
         @(posedge ref_clk);
         #1 k++;
      end
   endtask : hold_len
   task automatic pulse(input int i);
      @(posedge ref_clk);
      src <= 5'h01 ^ (5'h01 << i);
      @(posedge ref_clk);
      src <= 5'h01;
      #1;
   endtask : pulse
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   // ==========================================
   // sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'hA501_1122);
      wr(8'h04, 32'h7FFF_FFFF);
      check(one_byte_headers, 1'b1);
      rd(8'h04, 32'h1);
      wr(8'h05, 32'hFFFF_ABCD);
      rd(8'h05, 32'h0000_ABCD);
      check(node_id_value, 16'hABCD);
      wr(8'h04, 32'h8000_0000);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h8000_0000);
      wr(8'h80, 32'h0);
      rd(8'h80, 32'h0801);
      check(link_control, 32'h0801);
      wr(8'hD6, 32'hFFFF_1234);
      rd(8'hD6, 32'h1234);
      check(watchdog_timeout, 16'h1234);
      wr(8'hD7, 32'h0);
      check(watchdog_disable_value, 32'h0);
      wr(8'h50, 32'hFFFF_FFFC);
      check({mode_pins_out, mode_pins_oe}, 4'hC);
      check({usb_access_enable, usb_enable, usb_reset}, 3'h6);
      rd(8'h50, 32'h0103_000C);
      for (int i = 0; i < 4; i++) begin
         wr(8'h51, fv[i]);
         check(rsp.ack, i[0]);
      end
      rd(8'h51, 32'h64);
      check(sysclk_mhz, 7'h64);
      rd(8'h33, 32'h0);
      check(rsp.ack, 1'b0);
      wr(8'h50, 32'h2);
      check({rsp.valid, system_reset, tile_reset}, 3'h1);
      check({usb_enable, usb_reset, mode_pins_oe}, 4'h7);
      hold_len(1'b0, n);
      check(n inside {[14:19]}, 1'b1);
      wr(8'h50, 32'h1);
      check({rsp.valid, system_reset, tile_reset}, 3'h3);
      hold_len(1'b1, n);
      check(n inside {[18:22]}, 1'b1);
      hold_len(1'b0, n);
      rd(8'h04, 32'h0);
      rd(8'h51, 32'h19);
      rd(8'hD6, 32'h03E8);
      rd(8'hD7, 32'h0D15_AB1E);
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         check({system_reset, tile_reset}, i < 3 ? 2'h3 : 2'h1);
         hold_len(1'b1, n);
         hold_len(1'b0, n);
      end
      pulse(1);
      repeat (10) @(posedge ref_clk);
      pulse(2);
      hold_len(1'b1, n);
      check(n inside {[18:22]}, 1'b1);
      @(posedge ref_clk);
      osc_pin <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'hA500_1122);
      check({mode_pins_oe, usb_reset}, 3'h7);
      finish_test();
   end
   initial begin
      #30000;
      miscompares++;
      finish_test();
   end
endmodule : tb
bind analog_node_reset_config anode_assertions chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
   .cfg_resp(cfg_resp), .ext_reset_pin_n(ext_reset_pin_n),
   .brownout(brownout), .watchdog_expired(watchdog_expired),
   .sleep_sequence_reset(sleep_sequence_reset),
   .clock_source_change(clock_source_change),
   .system_reset(system_reset), .tile_reset(tile_reset),
   .mode_pins_out(mode_pins_out), .mode_pins_oe(mode_pins_oe),
   .usb_enable(usb_enable), .usb_reset(usb_reset));
`default_nettype wire
